// File: pkg/cis_regs.vh
// Constants for the card identity space: byte addresses, bit fields, reset values.
// Assumes byte-wide reads by the host, address counted in card bytes.
`ifndef CIS_REGS_VH
`define CIS_REGS_VH

// ----------------------------------------
// Byte addresses
// ----------------------------------------
`define CIS_LOW_ADDR 12'h000
`define CIS_EXT1_ADDR 12'h001
`define CIS_RSVD_ADDR 12'h002
`define CIS_COUNTRY_ADDR 12'h003
`define CIS_MANUF_LO_ADDR 12'h004
`define CIS_MANUF_HI_ADDR 12'h005
`define CIS_PROD_LO_ADDR 12'h006
`define CIS_PROD_HI_ADDR 12'h007
`define CIS_IRQ_MASK_ADDR 12'h008
`define CIS_IRQ_OFS0_ADDR 12'h009
`define CIS_IRQ_OFS1_ADDR 12'h00a
`define CIS_IRQ_OFS2_ADDR 12'h00b
`define CIS_FIQ_MASK_ADDR 12'h00c
`define CIS_FIQ_OFS0_ADDR 12'h00d
`define CIS_FIQ_OFS1_ADDR 12'h00e
`define CIS_FIQ_OFS2_ADDR 12'h00f
`define CIS_ID_END 12'h010
`define CIS_STATUS_ADDR 12'h010
`define CIS_PAGE_ADDR 12'hffc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIS_IRQ_BIT 0
`define CIS_PRESENT_BIT 1
`define CIS_FIQ_BIT 2
`define CIS_TYPE_LSB 3
`define CIS_TYPE_MSB 6
`define CIS_CONFORM_BIT 7
`define CIS_DIR_BIT 0
`define CIS_RELOC_BIT 1
`define CIS_WIDTH_LSB 2
`define CIS_WIDTH_MSB 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIS_PAGE_RESET 8'h00
`define CIS_BYTE_RESET 8'h00

`endif

// File: design/cis_sync.v
// Two-flop synchroniser for a bundle of asynchronous inputs.
// Assumes the bundle is quasi-static around the strobe that qualifies it.
`timescale 1ns/10ps

module cis_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] stage1;

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= INIT;
            q <= INIT;
        end
        else
        begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule

// File: design/cis_card_identity.v
// Card-side identity space: identity bytes, status pointers, page latch,
// interrupt line drivers and a pass-through to the card's own space.
// Assumes the host holds address and data stable while its strobe is low.
`timescale 1ns/10ps
`include "cis_regs.vh"

module cis_card_identity #(
    parameter ADDR_W = 12,
    parameter PAGE_W = 8,
    parameter HAS_EXT = 1,
    parameter RELOCATE = 0,
    parameter DIR_FOLLOWS = 0,
    parameter HAS_IRQ = 1,
    parameter HAS_FIQ = 1,
    parameter [3:0] TYPE_NIBBLE = 4'h1,
    parameter [1:0] CODE_WIDTH = 2'h0,
    // Arbitrary values, stand-ins for allocated codes
    parameter [15:0] MANUF_CODE = 16'h0a5a,
    parameter [15:0] PROD_CODE = 16'h0c3c
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Host bus
    input wire [ADDR_W-1:0] bus_addr,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire [7:0] backplane_data_in,
    output reg [7:0] backplane_data_out,
    output reg backplane_data_oe,
    // Interrupt lines, open drain
    output wire card_irq_n_out,
    output wire card_irq_n_oe,
    output wire card_fast_irq_n_out,
    output wire card_fast_irq_n_oe,
    // Card-side requests
    input wire irq_request,
    input wire fast_irq_request,
    // Card-side space
    output reg [PAGE_W-1:0] page,
    output wire [ADDR_W-1:0] user_addr,
    output reg user_rd_pulse,
    output reg user_wr_pulse,
    output reg [7:0] user_wr_data,
    input wire [7:0] user_rd_data
);

    // ----------------------------------------
    // Derived options
    // ----------------------------------------
    // Relocation needs the pointers that only an extended identity carries
    localparam RELOC_EFF = (HAS_EXT != 0) && (RELOCATE != 0);
    localparam DIR_EFF = (HAS_EXT != 0) && (DIR_FOLLOWS != 0);
    localparam [7:0] IRQ_MASK = (HAS_IRQ != 0) ? 8'h01 : 8'h00;
    localparam [7:0] FIQ_MASK = (HAS_FIQ != 0) ? 8'h04 : 8'h00;
    localparam [23:0] STATUS_OFS = RELOC_EFF ? {12'h000, `CIS_STATUS_ADDR} : 24'h000000;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [1:0] strobe_s;
    wire [ADDR_W+7:0] addr_data_s;
    wire rd_active;
    wire wr_active;
    wire [ADDR_W-1:0] addr_s;
    wire [7:0] data_s;

    cis_sync #(
        .W(2),
        .INIT(2'h3)
    ) u_sync_strobe (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d({bus_rd_n, bus_wr_n}),
        .q(strobe_s)
    );

    cis_sync #(
        .W(ADDR_W + 8),
        .INIT({(ADDR_W + 8){1'b0}})
    ) u_sync_addr_data (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d({bus_addr, backplane_data_in}),
        .q(addr_data_s)
    );

    assign rd_active = ~strobe_s[1];
    assign wr_active = ~strobe_s[0];
    assign addr_s = addr_data_s[ADDR_W+7:8];
    assign data_s = addr_data_s[7:0];
    assign user_addr = addr_s;

    // ----------------------------------------
    // Strobe edge detection
    // ----------------------------------------
    reg rd_active_d;
    reg wr_active_d;
    wire rd_start;
    wire wr_start;

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_active_d <= 1'b0;
            wr_active_d <= 1'b0;
        end
        else
        begin
            rd_active_d <= rd_active;
            wr_active_d <= wr_active;
        end
    end

    assign rd_start = rd_active & ~rd_active_d;
    assign wr_start = wr_active & ~wr_active_d;

    // ----------------------------------------
    // Interrupt line drivers
    // ----------------------------------------
    reg irq_drive;
    reg fiq_drive;

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_drive <= 1'b0;
            fiq_drive <= 1'b0;
        end
        else
        begin
            irq_drive <= irq_request & (HAS_IRQ != 0);
            fiq_drive <= fast_irq_request & (HAS_FIQ != 0);
        end
    end

    // Open drain: only ever pull low, the backplane pull-up gives the high
    assign card_irq_n_out = 1'b0;
    assign card_irq_n_oe = irq_drive;
    assign card_fast_irq_n_out = 1'b0;
    assign card_fast_irq_n_oe = fiq_drive;

    // ----------------------------------------
    // Status bits
    // ----------------------------------------
    // Taken straight from the driver flops so status and line never disagree
    wire [7:0] status_byte;
    wire low_irq;
    wire low_fiq;

    assign status_byte = {5'h00, fiq_drive, 1'b0, irq_drive};
    assign low_irq = RELOC_EFF ? 1'b0 : irq_drive;
    assign low_fiq = RELOC_EFF ? 1'b0 : fiq_drive;

    // ----------------------------------------
    // Identity bytes
    // ----------------------------------------
    wire [7:0] low_byte;
    wire [7:0] ext1_byte;
    wire [3:0] type_field;

    assign type_field = (HAS_EXT != 0) ? 4'h0 : TYPE_NIBBLE;

    assign low_byte = {1'b0, type_field, low_fiq, 1'b0, low_irq};

    assign ext1_byte = {4'h0, CODE_WIDTH, RELOC_EFF ? 1'b1 : 1'b0,
                        DIR_EFF ? 1'b1 : 1'b0};

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire page_zero;
    wire in_id_space;
    wire is_status;
    wire is_loc_zero;
    reg [7:0] id_data;
    reg [7:0] next_read_data;

    assign page_zero = (page == `CIS_PAGE_RESET);
    assign in_id_space = page_zero && (addr_s < `CIS_ID_END);
    assign is_status = RELOC_EFF && (addr_s == `CIS_STATUS_ADDR);
    assign is_loc_zero = (addr_s == `CIS_LOW_ADDR);

    always @*
    begin
        id_data = `CIS_BYTE_RESET;
        if (addr_s == `CIS_LOW_ADDR)
        begin
            id_data = low_byte;
        end
        else if (HAS_EXT != 0)
        begin
            case (addr_s)
                `CIS_EXT1_ADDR:
                    id_data = ext1_byte;
                `CIS_RSVD_ADDR:
                    id_data = 8'h00;
                `CIS_COUNTRY_ADDR:
                    id_data = 8'h00;
                `CIS_MANUF_LO_ADDR:
                    id_data = MANUF_CODE[7:0];
                `CIS_MANUF_HI_ADDR:
                    id_data = MANUF_CODE[15:8];
                `CIS_PROD_LO_ADDR:
                    id_data = PROD_CODE[7:0];
                `CIS_PROD_HI_ADDR:
                    id_data = PROD_CODE[15:8];
                `CIS_IRQ_MASK_ADDR:
                    id_data = IRQ_MASK;
                `CIS_IRQ_OFS0_ADDR:
                    id_data = STATUS_OFS[7:0];
                `CIS_IRQ_OFS1_ADDR:
                    id_data = STATUS_OFS[15:8];
                `CIS_IRQ_OFS2_ADDR:
                    id_data = STATUS_OFS[23:16];
                `CIS_FIQ_MASK_ADDR:
                    id_data = FIQ_MASK;
                `CIS_FIQ_OFS0_ADDR:
                    id_data = STATUS_OFS[7:0];
                `CIS_FIQ_OFS1_ADDR:
                    id_data = STATUS_OFS[15:8];
                `CIS_FIQ_OFS2_ADDR:
                    id_data = STATUS_OFS[23:16];
                default:
                    id_data = `CIS_BYTE_RESET;
            endcase
        end
    end

    // Status stays reachable on every page, identity only in page zero
    always @*
    begin
        if (is_status)
        begin
            next_read_data = status_byte;
        end
        else if (in_id_space)
        begin
            next_read_data = id_data;
        end
        else if (is_loc_zero)
        begin
            next_read_data = `CIS_BYTE_RESET;
        end
        else
        begin
            next_read_data = user_rd_data;
        end
    end

    // ----------------------------------------
    // Read data and bus drive
    // ----------------------------------------
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            backplane_data_out <= `CIS_BYTE_RESET;
            backplane_data_oe <= 1'b0;
        end
        else if (rd_start)
        begin
            backplane_data_out <= next_read_data;
            backplane_data_oe <= 1'b1;
        end
        else if (!rd_active)
        begin
            backplane_data_oe <= 1'b0;
        end
    end

    // ----------------------------------------
    // Card-side access forwarding
    // ----------------------------------------
    // Location zero and the identity never reach user logic, so start-up
    // probing cannot disturb read-sensitive hardware there
    wire fwd_ok;

    assign fwd_ok = !in_id_space && !is_status && !is_loc_zero;

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            user_rd_pulse <= 1'b0;
            user_wr_pulse <= 1'b0;
            user_wr_data <= `CIS_BYTE_RESET;
        end
        else
        begin
            user_rd_pulse <= rd_start & fwd_ok;
            user_wr_pulse <= wr_start & fwd_ok & (addr_s != `CIS_PAGE_ADDR);
            if (wr_start)
            begin
                user_wr_data <= data_s;
            end
        end
    end

    // ----------------------------------------
    // Page latch
    // ----------------------------------------
    // Writable on any page so a driver can always return to page zero
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            page <= `CIS_PAGE_RESET;
        end
        else if (wr_start && (addr_s == `CIS_PAGE_ADDR))
        begin
            page <= data_s[PAGE_W-1:0];
        end
    end

endmodule

// File: tb/cis_host_model.sv
// Host side of the card slot: resolves the data bus and interrupt lines.
// Assumes the card pins are sampled on core_clk.
`timescale 1ns/10ps

module cis_host_model (
    // Card pins
    input wire core_clk,
    input wire [7:0] data_out,
    input wire data_oe,
    input wire irq_out,
    input wire irq_oe,
    input wire fast_irq_out,
    input wire fast_irq_oe,
    // Host view
    output logic [7:0] host_byte,
    output wire card_absent,
    output wire try_ext_space,
    output wire card_irq_n,
    output wire card_fast_irq_n
);
    logic [7:0] last_byte = 8'h00;

    always @(posedge core_clk)
        if (data_oe)
            last_byte <= data_out;
    // Released bus: bit 1 pulled up, other bits must not keep the old value
    always_comb
        host_byte = data_oe ? data_out : {~last_byte[7:2], 1'b1, ~last_byte[0]};
    assign card_absent = host_byte[1];
    // No valid low byte: the host would go on to probe the extended access space
    assign try_ext_space = host_byte[1] | host_byte[7];
    // Open-drain lines with pull-ups
    assign card_irq_n = irq_oe ? irq_out : 1'b1;
    assign card_fast_irq_n = fast_irq_oe ? fast_irq_out : 1'b1;
endmodule

// File: tb/cis_card_identity_assertions.sv
// Port checks for the card identity space.
// Assumes the bench holds interrupt requests steady across a read.
`timescale 1ns/10ps

module cis_card_identity_assertions #(
    parameter ADDR_W = 12,
    parameter PAGE_W = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Host bus
    input wire bus_rd_n,
    input wire [7:0] backplane_data_out,
    input wire backplane_data_oe,
    // Interrupts
    input wire card_irq_n_out,
    input wire card_irq_n_oe,
    input wire card_fast_irq_n_out,
    input wire card_fast_irq_n_oe,
    input wire irq_request,
    input wire fast_irq_request,
    // Card side
    input wire [PAGE_W-1:0] page,
    input wire [ADDR_W-1:0] user_addr,
    input wire user_rd_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_id_read;
        $rose(backplane_data_oe) && user_addr == 0 && page == 0;
    endsequence

    a_irq_follow: assert property (arst_n && irq_request |=> card_irq_n_oe)
        else $error("irq drive late");
    a_irq_quiet: assert property (!irq_request |=> !card_irq_n_oe)
        else $error("irq drive stuck");
    a_fiq_follow: assert property (arst_n && fast_irq_request |=> card_fast_irq_n_oe)
        else $error("fast irq drive late");
    a_drain_low: assert property (!card_irq_n_out && !card_fast_irq_n_out)
        else $error("open drain level wrong");
    a_present_low: assert property (s_id_read |-> !backplane_data_out[1])
        else $error("present bit high");
    a_conform_zero: assert property (s_id_read |-> !backplane_data_out[7])
        else $error("conformance bit high");
    a_type_zero: assert property (s_id_read |-> backplane_data_out[6:3] == 4'h0)
        else $error("type nibble nonzero");
    a_irq_status: assert property (s_id_read |->
        backplane_data_out[0] == $past(card_irq_n_oe))
        else $error("irq status wrong");
    a_fiq_status: assert property (s_id_read |->
        backplane_data_out[2] == $past(card_fast_irq_n_oe))
        else $error("fast irq status wrong");
    a_page_reset: assert property (!$past(arst_n) |-> page == 0)
        else $error("page not zero after reset");
    a_no_fwd_zero: assert property (user_rd_pulse |-> user_addr != 0)
        else $error("location zero forwarded");
    a_oe_release: assert property ($rose(bus_rd_n) |-> ##[1:5] !backplane_data_oe)
        else $error("data enable held");
endmodule

bind cis_card_identity cis_card_identity_assertions #(
    .ADDR_W(ADDR_W),
    .PAGE_W(PAGE_W)
) cis_card_identity_assertions_inst (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .bus_rd_n(bus_rd_n),
    .backplane_data_out(backplane_data_out),
    .backplane_data_oe(backplane_data_oe),
    .card_irq_n_out(card_irq_n_out),
    .card_irq_n_oe(card_irq_n_oe),
    .card_fast_irq_n_out(card_fast_irq_n_out),
    .card_fast_irq_n_oe(card_fast_irq_n_oe),
    .irq_request(irq_request),
    .fast_irq_request(fast_irq_request),
    .page(page),
    .user_addr(user_addr),
    .user_rd_pulse(user_rd_pulse)
);

// File: tb/tb_card_identity_space.sv
// Testbench for the card identity space: host reads and writes on the pins.
// Assumes default parameters apart from the arbitrary maker and product codes.
`timescale 1ns/10ps

module tb_card_identity_space;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] bus_addr = 12'h000;
    logic bus_rd_n = 1'b1;
    logic bus_wr_n = 1'b1;
    logic [7:0] backplane_data_in = 8'h00;
    logic irq_request = 1'b0;
    logic fast_irq_request = 1'b0;
    wire [7:0] backplane_data_out, user_wr_data, host_byte, page;
    wire [11:0] user_addr;
    wire backplane_data_oe, card_irq_n_out, card_irq_n_oe, card_fast_irq_n_out;
    wire card_fast_irq_n_oe, user_rd_pulse, user_wr_pulse, card_absent, card_irq_n;
    wire card_fast_irq_n, try_ext_space;
    wire [7:0] user_rd_data = user_addr[7:0] ^ 8'h5a;
    int err_total = 0;
    int comparisons = 0;
    int rd_seen = 0;
    int wr_seen = 0;
    logic [7:0] wr_last = 8'h00;
    logic [7:0] id_exp [0:15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h34, 8'h12, 8'h67, 8'h05,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};

    // Maker and product codes are arbitrary
    cis_card_identity #(.MANUF_CODE(16'h1234), .PROD_CODE(16'h0567)) cis_card_identity_inst (
        .core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n),
        .bus_wr_n(bus_wr_n), .backplane_data_in(backplane_data_in),
        .backplane_data_out(backplane_data_out), .backplane_data_oe(backplane_data_oe),
        .card_irq_n_out(card_irq_n_out), .card_irq_n_oe(card_irq_n_oe),
        .card_fast_irq_n_out(card_fast_irq_n_out), .card_fast_irq_n_oe(card_fast_irq_n_oe),
        .irq_request(irq_request), .fast_irq_request(fast_irq_request), .page(page),
        .user_addr(user_addr), .user_rd_pulse(user_rd_pulse), .user_wr_pulse(user_wr_pulse),
        .user_wr_data(user_wr_data), .user_rd_data(user_rd_data));
    cis_host_model cis_host_model_inst (
        .core_clk(core_clk), .data_out(backplane_data_out), .data_oe(backplane_data_oe),
        .irq_out(card_irq_n_out), .irq_oe(card_irq_n_oe), .fast_irq_out(card_fast_irq_n_out),
        .fast_irq_oe(card_fast_irq_n_oe), .host_byte(host_byte), .card_absent(card_absent),
        .try_ext_space(try_ext_space),
        .card_irq_n(card_irq_n), .card_fast_irq_n(card_fast_irq_n));

    initial
        forever #12.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (user_rd_pulse === 1'b1)
            rd_seen++;
        if (user_wr_pulse === 1'b1)
        begin
            wr_seen++;
            wr_last <= user_wr_data;
        end
    end

    // ------
    // Tasks
    // ------
    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task wait_oe(input logic v);
        int n;
        n = 0;
        while (backplane_data_oe !== v && n < 12)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 12)
        begin
            err_total++;
            $display("unexpected at %0t: data enable stuck", $time);
            tally_and_finish;
        end
    endtask

    // Strobe held five cycles or more; address held until the card lets go
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd_n <= 1'b0;
        @(negedge core_clk);
        wait_oe(1'b1);
        repeat (2) @(negedge core_clk);
        chk(host_byte, e);
        if (a == 12'h000)
            chk({7'h00, card_absent}, 8'h00);
        if (a == 12'h000)
            chk({7'h00, try_ext_space}, 8'h00);
        @(posedge core_clk);
        bus_rd_n <= 1'b1;
        @(negedge core_clk);
        wait_oe(1'b0);
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        backplane_data_in <= d;
        bus_wr_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        bus_wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    initial
    begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++)
            rd(i[11:0], id_exp[i]);
        chk(rd_seen[7:0], 8'h00);
        @(posedge core_clk);
        irq_request <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk({7'h00, card_irq_n}, 8'h00);
        rd(12'h000, 8'h01);
        @(posedge core_clk);
        fast_irq_request <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk({7'h00, card_fast_irq_n}, 8'h00);
        rd(12'h000, 8'h05);
        @(posedge core_clk);
        irq_request <= 1'b0;
        rd(12'h000, 8'h04);
        @(posedge core_clk);
        fast_irq_request <= 1'b0;
        irq_request <= 1'b1;
        wr(12'hffc, 8'h01);
        chk(page, 8'h01);
        rd(12'h000, 8'h00);
        rd(12'h020, 8'h7a);
        chk(rd_seen[7:0], 8'h01);
        wr(12'h030, 8'ha5);
        chk(wr_seen[7:0], 8'h01);
        chk(wr_last, 8'ha5);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk(page, 8'h00);
        rd(12'h000, 8'h01);
        tally_and_finish;
    end
endmodule
